// ==== design/smle_defs.vh ====
// Purpose: Constants for the shift, move and literal execution block.
// Assumes: Included by its bare name from every design file of the block.
// Notes:   Definitions only; guarded against double inclusion.
//
// Summary of operation
// RQ1: Right shift: zero in, bit 0 to carry
// RQ2: Shift result to work or file by destination
// RQ3: File move copies value to work or file
// RQ4: File move always updates zero flag
// RQ5: Indirect port accesses memory at pointer address
// RQ6: Modes 00/01 pre-increment or pre-decrement pointer
// RQ7: Modes 10/11 post-increment or post-decrement pointer
// RQ8: Relative form adds signed offset, pointer unchanged
// RQ9: Pointers are 16 bits and wrap around
// RQ10: Bank literal loads five-bit bank select
// RQ11: Page literal loads seven-bit high latch
// RQ12: Work literal loads eight-bit work register
// RQ13: Pointer updates leave status flags unchanged
// RQ14: Zero flag follows eight-bit result value
// RQ15: Literal loads leave carry and zero alone
`ifndef SMLE_DEFS_VH
`define SMLE_DEFS_VH

// Instruction codes on the op port
`define SMLE_OP_NONE        3'h0
`define SMLE_OP_SHIFT_RIGHT 3'h1
`define SMLE_OP_MOVE_FILE   3'h2
`define SMLE_OP_IND_TO_WORK 3'h3
`define SMLE_OP_LOAD_BANK   3'h4
`define SMLE_OP_LOAD_PAGE   3'h5
`define SMLE_OP_LOAD_WORK   3'h6

// Pointer update mode codes
`define SMLE_MODE_PRE_INC   2'h0
`define SMLE_MODE_PRE_DEC   2'h1
`define SMLE_MODE_POST_INC  2'h2
`define SMLE_MODE_POST_DEC  2'h3

// File addresses of the two indirect data ports
`define SMLE_FILE_IND0      7'h00
`define SMLE_FILE_IND1      7'h01

// Register byte offsets on the bus
`define SMLE_REG_WORK       8'h00
`define SMLE_REG_STATUS     8'h04
`define SMLE_REG_BANK       8'h08
`define SMLE_REG_PAGE       8'h0C
`define SMLE_REG_FSEL0      8'h10
`define SMLE_REG_FSEL1      8'h14

// Status register fields
`define SMLE_ST_CARRY       0
`define SMLE_ST_ZERO        1
`define SMLE_ST_BUSY        2

// Reset values
`define SMLE_RST_WORK       8'h00
`define SMLE_RST_BANK       5'h00
`define SMLE_RST_PAGE       7'h00
`define SMLE_RST_FSEL       16'h0000

`endif

// ==== design/smle_ptr_unit.v ====
// Purpose: Effective address and updated value for one file-select pointer.
// Assumes: Purely combinational; the caller registers the results.
// Notes:   Offset is two's complement and sign-extended to pointer width.
`timescale 1ns/1ns
`default_nettype none
`include "smle_defs.vh"

module smle_ptr_unit #(
    parameter PW = 16,
    parameter OW = 6
) (
    input wire [PW-1:0] i_ptr,
    input wire [1:0] i_mode,
    input wire i_rel,
    input wire [OW-1:0] i_offset,
    output reg [PW-1:0] o_addr,
    output reg [PW-1:0] o_next_ptr
);

    reg [PW-1:0] ptr_inc;
    reg [PW-1:0] ptr_dec;
    reg [PW-1:0] offset_ext;

    always @* begin
        // Sums are kept at pointer width so they wrap, never saturate
        ptr_inc = i_ptr + {{(PW-1){1'b0}}, 1'b1}; // [RQ9]
        ptr_dec = i_ptr - {{(PW-1){1'b0}}, 1'b1}; // [RQ9]
        offset_ext = {{(PW-OW){i_offset[OW-1]}}, i_offset};
        o_addr = i_ptr;
        o_next_ptr = i_ptr;
        if (i_rel) begin
            o_addr = i_ptr + offset_ext; // [RQ8]
            o_next_ptr = i_ptr;
        end else begin
            case (i_mode)
                `SMLE_MODE_PRE_INC: begin
                    o_addr = ptr_inc; // [RQ6]
                    o_next_ptr = ptr_inc;
                end
                `SMLE_MODE_PRE_DEC: begin
                    o_addr = ptr_dec; // [RQ6]
                    o_next_ptr = ptr_dec;
                end
                `SMLE_MODE_POST_INC: begin
                    o_addr = i_ptr; // [RQ7]
                    o_next_ptr = ptr_inc;
                end
                default: begin
                    o_addr = i_ptr; // [RQ7]
                    o_next_ptr = ptr_dec;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ==== design/smle_exec.v ====
// Purpose: Executes right shift, file move, indirect move and literal loads.
// Assumes: Data memory answers a read one cycle after the cycle o_mem_rd is high.
// Notes:   Bus transfers and instructions never overlap; each waits for the other.
`timescale 1ns/1ns
`default_nettype none
`include "smle_defs.vh"

module smle_exec #(
    parameter PW = 16,
    parameter OW = 6
) (
    input wire i_core_clk,
    input wire i_nrst,
    input wire i_ce,
    // AHB-Lite slave
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire [31:0] i_hwdata,
    input wire i_hready,
    output reg o_hreadyout,
    output reg [31:0] o_hrdata,
    output reg o_hresp,
    // Instruction from the fetch stage
    input wire i_instr_valid,
    input wire [2:0] i_op,
    input wire i_dest,
    input wire [6:0] i_file,
    input wire [7:0] i_lit,
    input wire i_ptr_sel,
    input wire [1:0] i_mode,
    input wire i_rel,
    output reg o_instr_ready,
    // Data memory
    output reg [PW-1:0] o_mem_addr,
    output reg o_mem_rd,
    output reg o_mem_we,
    output reg [7:0] o_mem_wdata,
    input wire [7:0] i_mem_rdata,
    // Core state
    output reg [7:0] o_work,
    output reg o_carry,
    output reg o_zero,
    output reg [4:0] o_bank,
    output reg [6:0] o_page,
    output reg [PW-1:0] o_fsel0,
    output reg [PW-1:0] o_fsel1
);

    localparam [1:0] S_IDLE = 2'd0;
    localparam [1:0] S_READ = 2'd1;
    localparam [1:0] S_DATA = 2'd2;
    localparam [1:0] S_WBACK = 2'd3;

    reg [1:0] state;
    reg [2:0] op_q;
    reg dest_q;
    reg bus_pend;
    reg bus_wr;
    reg [7:0] bus_addr;

    reg [1:0] next_state;
    reg next_pend;
    reg [7:0] result;
    reg result_carry;
    reg [PW-1:0] sel_ptr;
    reg [PW-1:0] file_addr;

    wire [PW-1:0] ptr_addr;
    wire [PW-1:0] ptr_next;
    wire addr_taken;
    wire instr_take;
    wire bus_done;
    wire needs_mem;
    wire file_is_ind;

    smle_ptr_unit #(
        .PW(PW),
        .OW(OW)
    ) u_ptr (
        .i_ptr(sel_ptr),
        .i_mode(i_mode),
        .i_rel(i_rel),
        .i_offset(i_lit[OW-1:0]),
        .o_addr(ptr_addr),
        .o_next_ptr(ptr_next)
    );

    assign addr_taken = i_hsel & i_htrans[1] & i_hready;
    // Pending bus transfer has priority over a new instruction
    assign bus_done = bus_pend & (state == S_IDLE);
    assign instr_take = i_instr_valid & o_instr_ready & ~bus_pend;
    assign needs_mem = (i_op == `SMLE_OP_SHIFT_RIGHT) | (i_op == `SMLE_OP_MOVE_FILE) |
                       (i_op == `SMLE_OP_IND_TO_WORK);
    assign file_is_ind = (i_file == `SMLE_FILE_IND0) | (i_file == `SMLE_FILE_IND1);

    always @* begin
        sel_ptr = i_ptr_sel ? o_fsel1 : o_fsel0;
        // Indirect data port has no storage: the pointer is the address
        if (file_is_ind) begin
            if (i_file == `SMLE_FILE_IND1) begin
                file_addr = o_fsel1; // [RQ5]
            end else begin
                file_addr = o_fsel0; // [RQ5]
            end
        end else begin
            file_addr = {{(PW-12){1'b0}}, o_bank, i_file};
        end
    end

    always @* begin
        result = i_mem_rdata;
        result_carry = o_carry;
        if (op_q == `SMLE_OP_SHIFT_RIGHT) begin
            result = {1'b0, i_mem_rdata[7:1]}; // [RQ1]
            result_carry = i_mem_rdata[0]; // [RQ1]
        end
    end

    always @* begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (instr_take && needs_mem) begin
                    next_state = S_READ;
                end
            end
            S_READ: begin
                next_state = S_DATA;
            end
            S_DATA: begin
                if (dest_q && op_q != `SMLE_OP_IND_TO_WORK) begin
                    next_state = S_WBACK;
                end else begin
                    next_state = S_IDLE;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        next_pend = bus_pend;
        if (bus_done) begin
            next_pend = 1'b0;
        end
        if (addr_taken) begin
            next_pend = 1'b1;
        end
    end

    // Instruction sequencing and core state
    always @(posedge i_core_clk) begin
        if (!i_nrst) begin
            state <= S_IDLE;
            op_q <= `SMLE_OP_NONE;
            dest_q <= 1'b0;
            o_instr_ready <= 1'b0;
            o_mem_addr <= {PW{1'b0}};
            o_mem_rd <= 1'b0;
            o_mem_we <= 1'b0;
            o_mem_wdata <= 8'h00;
            o_work <= `SMLE_RST_WORK;
            o_carry <= 1'b0;
            o_zero <= 1'b0;
            o_bank <= `SMLE_RST_BANK;
            o_page <= `SMLE_RST_PAGE;
            o_fsel0 <= `SMLE_RST_FSEL;
            o_fsel1 <= `SMLE_RST_FSEL;
        end else if (i_ce) begin
            state <= next_state;
            o_instr_ready <= (next_state == S_IDLE) & ~next_pend;
            o_mem_rd <= 1'b0;
            o_mem_we <= 1'b0;
            if (instr_take) begin
                op_q <= i_op;
                dest_q <= i_dest;
                case (i_op)
                    `SMLE_OP_SHIFT_RIGHT, `SMLE_OP_MOVE_FILE: begin
                        o_mem_addr <= file_addr;
                        o_mem_rd <= 1'b1;
                    end
                    `SMLE_OP_IND_TO_WORK: begin
                        o_mem_addr <= ptr_addr; // [RQ6] [RQ7] [RQ8]
                        o_mem_rd <= 1'b1;
                        // Pointer moves now; flags stay untouched here
                        if (i_ptr_sel) begin
                            o_fsel1 <= ptr_next; // [RQ7] [RQ13]
                        end else begin
                            o_fsel0 <= ptr_next; // [RQ7] [RQ13]
                        end
                    end
                    `SMLE_OP_LOAD_BANK: begin
                        o_bank <= i_lit[4:0]; // [RQ10] [RQ15]
                    end
                    `SMLE_OP_LOAD_PAGE: begin
                        o_page <= i_lit[6:0]; // [RQ11] [RQ15]
                    end
                    `SMLE_OP_LOAD_WORK: begin
                        o_work <= i_lit; // [RQ12] [RQ15]
                    end
                    default: begin
                        o_mem_rd <= 1'b0;
                    end
                endcase
            end else if (state == S_DATA) begin
                o_zero <= (result == 8'h00); // [RQ4] [RQ14]
                if (op_q == `SMLE_OP_SHIFT_RIGHT) begin
                    o_carry <= result_carry; // [RQ1]
                end
                if (dest_q && op_q != `SMLE_OP_IND_TO_WORK) begin
                    // Written back to the same address it was read from
                    o_mem_we <= 1'b1; // [RQ2] [RQ3]
                    o_mem_wdata <= result;
                end else begin
                    o_work <= result; // [RQ2] [RQ3]
                end
            end else if (bus_done && bus_wr) begin
                if (bus_addr == `SMLE_REG_WORK) begin
                    o_work <= i_hwdata[7:0];
                end else if (bus_addr == `SMLE_REG_STATUS) begin
                    o_carry <= i_hwdata[`SMLE_ST_CARRY];
                    o_zero <= i_hwdata[`SMLE_ST_ZERO];
                end else if (bus_addr == `SMLE_REG_BANK) begin
                    o_bank <= i_hwdata[4:0];
                end else if (bus_addr == `SMLE_REG_PAGE) begin
                    o_page <= i_hwdata[6:0];
                end else if (bus_addr == `SMLE_REG_FSEL0) begin
                    o_fsel0 <= i_hwdata[PW-1:0];
                end else if (bus_addr == `SMLE_REG_FSEL1) begin
                    o_fsel1 <= i_hwdata[PW-1:0];
                end
            end
        end
    end

    // Bus slave: every transfer takes one wait state at least, longer
    // while an instruction is in flight, so core state never sees two writers
    always @(posedge i_core_clk) begin
        if (!i_nrst) begin
            bus_pend <= 1'b0;
            bus_wr <= 1'b0;
            bus_addr <= 8'h00;
            o_hreadyout <= 1'b1;
            o_hrdata <= 32'h0000_0000;
            o_hresp <= 1'b0;
        end else if (i_ce) begin
            bus_pend <= next_pend;
            o_hreadyout <= ~next_pend;
            o_hresp <= 1'b0;
            if (addr_taken) begin
                bus_wr <= i_hwrite;
                // Upper address bits are not decoded; the map aliases
                bus_addr <= {i_haddr[7:2], 2'b00};
            end
            if (bus_done && !bus_wr) begin
                if (bus_addr == `SMLE_REG_WORK) begin
                    o_hrdata <= {24'h00_0000, o_work};
                end else if (bus_addr == `SMLE_REG_STATUS) begin
                    o_hrdata <= {29'h0000_0000, (state != S_IDLE), o_zero, o_carry};
                end else if (bus_addr == `SMLE_REG_BANK) begin
                    o_hrdata <= {27'h000_0000, o_bank};
                end else if (bus_addr == `SMLE_REG_PAGE) begin
                    o_hrdata <= {25'h000_0000, o_page};
                end else if (bus_addr == `SMLE_REG_FSEL0) begin
                    o_hrdata <= {{(32-PW){1'b0}}, o_fsel0};
                end else if (bus_addr == `SMLE_REG_FSEL1) begin
                    o_hrdata <= {{(32-PW){1'b0}}, o_fsel1};
                end else begin
                    o_hrdata <= 32'h0000_0000;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ==== test/smle_mem_model.sv ====
// Purpose: Data memory beside the execution block.
// Assumes: A read answers in the cycle after the read strobe.
// Notes: Only the low address byte picks a cell; cell i starts as i.
`timescale 1ns/1ns
`default_nettype none
module smle_mem_model (
    input wire logic i_core_clk,
    input wire logic [15:0] i_addr,
    input wire logic i_rd,
    input wire logic i_we,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:255];
    initial begin
        o_rdata = 8'h00;
        for (int i = 0; i < 256; i++) begin
            mem[i] = i[7:0];
        end
    end
    // Data flips outside the answer cycle so a stale byte never looks right
    always @(posedge i_core_clk) begin
        o_rdata <= i_rd ? mem[i_addr[7:0]] : ~o_rdata;
        if (i_we) begin
            mem[i_addr[7:0]] <= i_wdata;
        end
    end
endmodule
`default_nettype wire

// ==== test/smle_exec_sva.sv ====
// Purpose: Port-level checks of the execution block.
// Assumes: i_ce stays high while an instruction runs.
// Notes: Bound to smle_exec at the foot.
`timescale 1ns/1ns
`default_nettype none
`include "smle_defs.vh"
module smle_exec_sva #(
    parameter PW = 16,
    parameter OW = 6
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_instr_valid,
    input wire logic [2:0] i_op,
    input wire logic i_dest,
    input wire logic [7:0] i_lit,
    input wire logic i_ptr_sel,
    input wire logic [1:0] i_mode,
    input wire logic i_rel,
    input wire logic o_instr_ready,
    input wire logic [PW-1:0] o_mem_addr,
    input wire logic o_mem_we,
    input wire logic [7:0] o_mem_wdata,
    input wire logic [7:0] i_mem_rdata,
    input wire logic [7:0] o_work,
    input wire logic o_carry,
    input wire logic o_zero,
    input wire logic [PW-1:0] o_fsel0,
    input wire logic [PW-1:0] o_fsel1
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    wire tk = i_instr_valid && o_instr_ready && i_ce;
    wire sr = tk && i_op == `SMLE_OP_SHIFT_RIGHT;
    wire mf = tk && i_op == `SMLE_OP_MOVE_FILE;
    wire iw = tk && i_op == `SMLE_OP_IND_TO_WORK && !i_rel;
    wire ir = tk && i_op == `SMLE_OP_IND_TO_WORK && i_rel;
    wire [PW-1:0] ofs = {{(PW-OW){i_lit[OW-1]}}, i_lit[OW-1:0]};
    a_shift_flags:
        assert property (sr ##2 1 |=> o_carry == $past(i_mem_rdata[0])
            && o_zero == ($past(i_mem_rdata[7:1]) == 7'h0)) else $error("shift flags");
    a_shift_back:
        assert property (sr && i_dest |-> ##3 o_mem_we
            && o_mem_wdata == {1'b0, $past(i_mem_rdata[7:1])}) else $error("shift back");
    a_move_zero:
        assert property (mf ##2 1 |=> o_zero == ($past(i_mem_rdata) == 8'h0)
            && $stable(o_carry)) else $error("move zero");
    a_move_work:
        assert property (mf && !i_dest |-> ##3 o_work == $past(i_mem_rdata)
            && !o_mem_we) else $error("move work");
    a_pre_inc:
        assert property (iw && i_mode == `SMLE_MODE_PRE_INC && !i_ptr_sel |=>
            o_fsel0 == $past(o_fsel0) + 16'h1 && o_mem_addr == o_fsel0) else $error("pre inc");
    a_post_dec:
        assert property (iw && i_mode == `SMLE_MODE_POST_DEC && i_ptr_sel |=>
            o_fsel1 == $past(o_fsel1) - 16'h1 && o_mem_addr == $past(o_fsel1)) else $error("post dec");
    a_rel_offset:
        assert property (ir && i_ptr_sel |=> $stable(o_fsel1)
            && o_mem_addr == $past(o_fsel1) + $past(ofs)) else $error("rel offset");
    a_ind_carry:
        assert property (iw || ir |=> $stable(o_carry) [*4]) else $error("ind carry");
    a_ind_result:
        assert property ((iw || ir) ##2 1 |=> o_work == $past(i_mem_rdata)
            && o_zero == ($past(i_mem_rdata) == 8'h0)) else $error("ind result");
    a_lit_work:
        assert property (tk && i_op == `SMLE_OP_LOAD_WORK |=> o_work == $past(i_lit)
            && $stable(o_carry) && $stable(o_zero)) else $error("lit work");
endmodule
bind smle_exec smle_exec_sva #(.PW(PW), .OW(OW)) u_smle_exec_sva (.*);
`default_nettype wire

// ==== test/tb_smle_exec.sv ====
// Purpose: Self-checking bench for the execution block.
// Assumes: Memory model answers one cycle after a read strobe.
// Notes: Reset, a mid-run reset and clock-enable freezing get hand-written tests.
`timescale 1ns/1ns
`default_nettype none
`include "smle_defs.vh"
module tb_smle_exec;
    typedef struct packed {
        logic [2:0] op;
        logic d;
        logic [6:0] f;
        logic [7:0] lit;
        logic sel;
        logic [1:0] mode;
        logic rel;
        logic [7:0] w;
        logic c;
        logic z;
        logic [15:0] p0;
        logic [15:0] p1;
    } smle_row_t;
    localparam logic [2:0] SR = 3'h1, MF = 3'h2, IW = 3'h3, LB = 3'h4, LP = 3'h5, LW = 3'h6;
    localparam logic [15:0] FF = 16'hffff, T = 16'h0010, E = 16'h000e;
    logic i_core_clk = 1'b0, i_nrst = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0;
    logic i_instr_valid = 1'b0, i_dest = 1'b0, i_ptr_sel = 1'b0, i_rel = 1'b0, i_ce = 1'b1;
    logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, rd;
    logic [1:0] i_htrans = 2'h0, i_mode = 2'h0;
    logic [2:0] i_op = 3'h0;
    logic [6:0] i_file = 7'h0;
    logic [7:0] i_lit = 8'h0;
    wire logic o_hreadyout, o_hresp, o_instr_ready, o_mem_rd, o_mem_we, o_carry, o_zero;
    wire logic [31:0] o_hrdata;
    wire logic [15:0] o_mem_addr, o_fsel0, o_fsel1;
    wire logic [7:0] o_mem_wdata, o_work, mem_rdata;
    wire logic [4:0] o_bank;
    wire logic [6:0] o_page;
    int num_errors = 0, num_checks = 0, cyc = 0;
    smle_row_t rows [18] = '{
        '{LW, 0, 0, 8'hff, 0, 0, 0, 8'hff, 0, 0, FF, T},
        '{SR, 0, 7'h03, 0, 0, 0, 0, 8'h01, 1, 0, FF, T},
        '{LW, 0, 0, 8'h00, 0, 0, 0, 8'h00, 1, 0, FF, T},
        '{SR, 1, 7'h02, 0, 0, 0, 0, 8'h00, 0, 0, FF, T},
        '{MF, 0, 7'h02, 0, 0, 0, 0, 8'h01, 0, 0, FF, T},
        '{SR, 1, 7'h02, 0, 0, 0, 0, 8'h01, 1, 1, FF, T},
        '{MF, 1, 7'h01, 0, 0, 0, 0, 8'h01, 1, 0, FF, T},
        '{MF, 1, 7'h02, 0, 0, 0, 0, 8'h01, 1, 1, FF, T},
        '{IW, 0, 0, 0, 0, 2'h0, 0, 8'h00, 1, 1, 16'h0, T},
        '{IW, 0, 0, 0, 1, 2'h3, 0, 8'h10, 1, 0, 16'h0, 16'h000f},
        '{IW, 0, 0, 0, 1, 2'h1, 0, 8'h0e, 1, 0, 16'h0, E},
        '{IW, 0, 0, 0, 0, 2'h1, 0, 8'hff, 1, 0, FF, E},
        '{IW, 0, 0, 0, 0, 2'h2, 0, 8'hff, 1, 0, 16'h0, E},
        '{IW, 0, 0, 8'h3e, 1, 2'h2, 1, 8'h0c, 1, 0, 16'h0, E},
        '{IW, 0, 0, 8'h1f, 0, 2'h2, 1, 8'h1f, 1, 0, 16'h0, E},
        '{IW, 0, 0, 8'h20, 1, 2'h0, 1, 8'hee, 1, 0, 16'h0, E},
        '{LB, 0, 0, 8'h0f, 0, 0, 0, 0, 0, 0, 0, 0},
        '{LP, 0, 0, 8'h7f, 0, 0, 0, 0, 0, 0, 0, 0}};
    smle_exec u_smle_exec (.i_hsize(3'h2), .i_hready(o_hreadyout),
        .i_mem_rdata(mem_rdata), .*);
    smle_mem_model u_smle_mem_model (.i_core_clk(i_core_clk), .i_addr(o_mem_addr),
        .i_rd(o_mem_rd), .i_we(o_mem_we), .i_wdata(o_mem_wdata), .o_rdata(mem_rdata));
    always #20 i_core_clk = ~i_core_clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Reset for three edges, then watch the first two edges after release
    task automatic reset_dut;
        i_nrst <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        chk({o_work, o_bank, o_page, o_carry, o_zero, o_hreadyout}, 32'h1);
        chk({o_fsel0, o_fsel1}, 32'h0);
        @(posedge i_core_clk);
        chk({o_instr_ready, o_hresp, o_mem_rd, o_mem_we}, 32'h0);
        @(posedge i_core_clk);
        chk(o_instr_ready, 32'h1);
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        i_hsel <= 1'b1;
        i_htrans <= 2'h2;
        i_hwrite <= wr;
        i_haddr <= {24'h0, a};
        @(posedge i_core_clk);
        while (o_hreadyout !== 1'b1) @(posedge i_core_clk);
        i_htrans <= 2'h0;
        i_hwdata <= wd;
        @(posedge i_core_clk);
        while (o_hreadyout !== 1'b1) @(posedge i_core_clk);
        rd = o_hrdata;
        // Select stays up; an IDLE htrans is the gap between transfers
        chk(o_hresp, 32'h0);
    endtask
    // With hold set the offer stays up, so literals can follow back to back
    task automatic run(input smle_row_t r, input logic hold);
        i_instr_valid <= 1'b1;
        {i_op, i_dest, i_file, i_lit, i_ptr_sel, i_mode, i_rel} <= r[64:42];
        @(posedge i_core_clk);
        while (o_instr_ready !== 1'b1) @(posedge i_core_clk);
        if (!hold) begin
            i_instr_valid <= 1'b0;
            repeat (5) @(posedge i_core_clk);
        end
    endtask
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            complete_run;
        end
    end
    initial begin
        reset_dut;
        bus(1'b1, `SMLE_REG_FSEL0, 32'h0000_ffff);
        bus(1'b1, `SMLE_REG_FSEL1, 32'h0000_0010);
        bus(1'b0, `SMLE_REG_FSEL0, 32'h0);
        chk(rd, 32'h0000_ffff);
        // Unmapped read follows a nonzero one so a stale word would show
        bus(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        for (int k = 0; k < 16; k++) begin
            run(rows[k], 1'b0);
            chk(o_work, rows[k].w);
            chk({o_carry, o_zero}, {rows[k].c, rows[k].z});
            chk({o_fsel0, o_fsel1}, {rows[k].p0, rows[k].p1});
        end
        run(rows[16], 1'b1);
        run(rows[17], 1'b1);
        i_instr_valid <= 1'b0;
        @(posedge i_core_clk);
        chk({o_bank, o_page}, {5'h0f, 7'h7f});
        chk({o_carry, o_zero}, 2'h2);
        bus(1'b0, `SMLE_REG_STATUS, 32'h0);
        chk(rd, 32'h1);
        bus(1'b0, `SMLE_REG_PAGE, 32'h0);
        chk(rd, 32'h0000_007f);
        bus(1'b0, `SMLE_REG_FSEL0, 32'h0);
        chk(rd, 32'h0);
        // Mid-run reset, then a literal held off while the clock enable is low
        reset_dut;
        i_ce <= 1'b0;
        i_instr_valid <= 1'b1;
        {i_op, i_lit} <= {LW, 8'h5a};
        repeat (3) @(posedge i_core_clk);
        chk(o_work, 32'h0);
        i_ce <= 1'b1;
        @(posedge i_core_clk);
        i_instr_valid <= 1'b0;
        @(posedge i_core_clk);
        chk(o_work, 32'h5a);
        bus(1'b1, `SMLE_REG_STATUS, 32'h0000_0003);
        bus(1'b0, `SMLE_REG_STATUS, 32'h0);
        chk(rd, 32'h0000_0003);
        complete_run;
    end
endmodule
`default_nettype wire
